// file: rtl/mfs_flag.sv
`timescale 1ns/100ps
`include "mfs_params.svh"

// One sticky flag: hardware sets, software clears by writing one
module mfs_flag (
	input wire logic clk,
	input wire logic rst,
	input wire logic set, // Event from the core
	input wire logic clr, // Write of one from software
	output logic q
);

	logic next_q;

	// Set wins over a clear in the same cycle so no event is lost
	always_comb begin
		next_q = set | (q & ~clr); // [RULE11] [RULE3]
	end

	// Flag storage, zero after reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q <= `MFS_FLAG_RST; // [RULE3]
		end else begin
			q <= next_q;
		end
	end

	// A set always leaves the flag high next cycle
	AST_FLAG_SET_WINS: assert property (@(posedge clk) disable iff (rst)
		set |=> q) else $error("flag lost on set"); // [RULE11]

endmodule

// file: rtl/mfs_params.svh
// How it works
// RULE1: Unstack violation on return sets bit 3
// RULE2: Unstack fault chains, keeps SP, frame, address
// RULE3: Flags reset to zero, write-one clears
// RULE4: Bit 2 reserved, always reads zero
// RULE5: Forbidden load or store sets bit 1
// RULE6: Data fault stacks faulting PC, captures address
// RULE7: Fetch from non-executable location sets bit 0
// RULE8: Execute-never fetch faults even without protection
// RULE9: Instruction fault stacks faulting PC, no address
// RULE10: Address-valid flag set only by address-loading faults
// RULE11: Zero write keeps flag; set beats clear
`ifndef MFS_PARAMS_SVH
`define MFS_PARAMS_SVH

// Register byte offsets
`define MFS_OFF_STATUS 4'h0
`define MFS_OFF_MASK 4'h4
`define MFS_OFF_ADDR 4'h8
`define MFS_OFF_CTRL 4'hC

// Field positions in status, mask and control
`define MFS_BIT_INSTR 0
`define MFS_BIT_DATA 1
`define MFS_BIT_RSVD 2
`define MFS_BIT_UNSTACK 3
`define MFS_BIT_ADDR_VALID 7
`define MFS_BIT_PROT_EN 0

// Reset values
`define MFS_FLAG_RST 1'b0
`define MFS_MASK_RST 4'h0
`define MFS_CTRL_RST 1'b0
`define MFS_ADDR_RST 32'h0000_0000

// AXI responses
`define MFS_RESP_OKAY 2'h0
`define MFS_RESP_SLVERR 2'h2

// Number of sticky flags held by the flag cells
`define MFS_NUM_FLAGS 4

`endif

// file: rtl/mfs_pkg.sv
package mfs_pkg;

	// Index of each sticky flag inside the flag-cell vector
	typedef enum logic [1:0] {
		MFS_FL_INSTR = 2'h0,
		MFS_FL_DATA = 2'h1,
		MFS_FL_UNSTACK = 2'h2,
		MFS_FL_VALID = 2'h3
	} mfs_flag_idx_t;

	// Register selected by an access
	typedef enum logic [2:0] {
		MFS_SEL_STATUS = 3'h0,
		MFS_SEL_MASK = 3'h1,
		MFS_SEL_ADDR = 3'h2,
		MFS_SEL_CTRL = 3'h3,
		MFS_SEL_NONE = 3'h4
	} mfs_sel_t;

endpackage

// file: rtl/mfs_top.sv
// The address map and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/100ps
`include "mfs_params.svh"

// Memory-protection fault status, low bits, with an AXI4-Lite slave
module mfs_top (
	input wire logic CLK,
	input wire logic RST,
	// AXI4-Lite write address
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [3:0] AWADDR,
	// AXI4-Lite write data
	input wire logic WVALID,
	output logic WREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	// AXI4-Lite write response
	output logic BVALID,
	input wire logic BREADY,
	output logic [1:0] BRESP,
	// AXI4-Lite read address
	input wire logic ARVALID,
	output logic ARREADY,
	input wire logic [3:0] ARADDR,
	// AXI4-Lite read data
	output logic RVALID,
	input wire logic RREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	// Core: return unstacking
	input wire logic UNSTACK_VALID,
	input wire logic UNSTACK_DENY,
	// Core: data load or store
	input wire logic ACCESS_VALID,
	input wire logic ACCESS_DENY,
	input wire logic [31:0] ACCESS_ADDR,
	// Core: instruction fetch issue
	input wire logic FETCH_VALID,
	input wire logic FETCH_DENY,
	input wire logic EXECUTE_NEVER_REGION,
	// PC of the instruction in flight
	input wire logic [31:0] INSTR_PC,
	// Fault consequences towards the core
	output logic FAULT_CHAIN,
	output logic SP_HOLD,
	output logic SAVE_SKIP,
	output logic STACK_PC_VALID,
	output logic [31:0] STACK_PC,
	output logic [31:0] MEM_FAULT_ADDRESS_REG,
	output logic IRQ
);

	// Fault events of this cycle
	logic unstack_evt;
	logic data_evt;
	logic instr_evt;

	// Sticky flag vector and its set and clear terms
	logic [`MFS_NUM_FLAGS-1:0] flag_q;
	logic [`MFS_NUM_FLAGS-1:0] flag_set;
	logic [`MFS_NUM_FLAGS-1:0] flag_clr;

	// Software state
	logic [3:0] mask; // Gates flags onto IRQ, status layout of bits 3:0
	logic prot_en; // Protection checks on; does not gate execute-never
	logic [31:0] next_fault_addr;
	logic [3:0] next_mask;
	logic next_prot_en;

	// Bus state
	logic aw_held;
	logic w_held;
	logic [3:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic next_aw_held;
	logic next_w_held;
	logic [3:0] next_aw_addr;
	logic [31:0] next_w_data;
	logic [3:0] next_w_strb;
	logic next_bvalid;
	logic [1:0] next_bresp;
	logic next_rvalid;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;
	logic wr_fire; // Both halves of a write are held this cycle
	mfs_pkg::mfs_sel_t wr_sel;
	mfs_pkg::mfs_sel_t rd_sel;

	// Core-side registered outputs
	logic next_chain;
	logic next_stack_pc_valid;
	logic [31:0] next_stack_pc;
	logic next_irq;

	// Status word as software sees it
	logic [31:0] status_word;

	// Map a byte offset onto a register
	function automatic mfs_pkg::mfs_sel_t decode(input logic [3:0] a);
		mfs_pkg::mfs_sel_t s;
		s = mfs_pkg::MFS_SEL_NONE;
		case (a)
			`MFS_OFF_STATUS: s = mfs_pkg::MFS_SEL_STATUS;
			`MFS_OFF_MASK: s = mfs_pkg::MFS_SEL_MASK;
			`MFS_OFF_ADDR: s = mfs_pkg::MFS_SEL_ADDR;
			`MFS_OFF_CTRL: s = mfs_pkg::MFS_SEL_CTRL;
			default: s = mfs_pkg::MFS_SEL_NONE;
		endcase
		return s;
	endfunction

	// Fault detection from the core's access attributes
	always_comb begin
		unstack_evt = UNSTACK_VALID & UNSTACK_DENY; // [RULE1]
		data_evt = ACCESS_VALID & prot_en & ACCESS_DENY; // [RULE5]
		// Execute-never faults whether or not protection is on
		instr_evt = FETCH_VALID & (EXECUTE_NEVER_REGION | (prot_en & FETCH_DENY)); // [RULE7] [RULE8]
	end

	// Status word: reserved bit 2 and bits 6:4 read as zero
	always_comb begin
		status_word = 32'h0000_0000;
		status_word[`MFS_BIT_INSTR] = flag_q[mfs_pkg::MFS_FL_INSTR];
		status_word[`MFS_BIT_DATA] = flag_q[mfs_pkg::MFS_FL_DATA];
		status_word[`MFS_BIT_RSVD] = 1'b0; // [RULE4]
		status_word[`MFS_BIT_UNSTACK] = flag_q[mfs_pkg::MFS_FL_UNSTACK];
		status_word[`MFS_BIT_ADDR_VALID] = flag_q[mfs_pkg::MFS_FL_VALID];
	end

	// Write channel: address and data are taken in either order
	always_comb begin
		wr_sel = decode(aw_addr);
		wr_fire = aw_held & w_held & ~BVALID;
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_aw_addr = aw_addr;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = BVALID;
		next_bresp = BRESP;
		if (AWVALID && AWREADY) begin
			next_aw_held = 1'b1;
			next_aw_addr = AWADDR;
		end
		if (WVALID && WREADY) begin
			next_w_held = 1'b1;
			next_w_data = WDATA;
			next_w_strb = WSTRB;
		end
		// Perform the write and raise the response
		if (wr_fire) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = (wr_sel == mfs_pkg::MFS_SEL_NONE) ? `MFS_RESP_SLVERR : `MFS_RESP_OKAY;
		end else if (BVALID && BREADY) begin
			next_bvalid = 1'b0;
		end
	end

	// Write effects: only byte lane 0 carries writable bits
	always_comb begin
		flag_clr = '0;
		next_mask = mask;
		next_prot_en = prot_en;
		if (wr_fire && w_strb[0]) begin
			if (wr_sel == mfs_pkg::MFS_SEL_STATUS) begin
				// Ones clear, zeros leave the flag alone
				flag_clr[mfs_pkg::MFS_FL_INSTR] = w_data[`MFS_BIT_INSTR]; // [RULE3] [RULE11]
				flag_clr[mfs_pkg::MFS_FL_DATA] = w_data[`MFS_BIT_DATA]; // [RULE3] [RULE11]
				flag_clr[mfs_pkg::MFS_FL_UNSTACK] = w_data[`MFS_BIT_UNSTACK]; // [RULE3]
				flag_clr[mfs_pkg::MFS_FL_VALID] = w_data[`MFS_BIT_ADDR_VALID]; // [RULE3]
			end else if (wr_sel == mfs_pkg::MFS_SEL_MASK) begin
				next_mask = w_data[3:0];
				next_mask[`MFS_BIT_RSVD] = 1'b0;
			end else if (wr_sel == mfs_pkg::MFS_SEL_CTRL) begin
				next_prot_en = w_data[`MFS_BIT_PROT_EN];
			end
		end
	end

	// Read channel: one read at a time, answered the cycle after it is taken
	always_comb begin
		rd_sel = decode(ARADDR);
		next_rvalid = RVALID;
		next_rdata = RDATA;
		next_rresp = RRESP;
		if (ARVALID && ARREADY) begin
			next_rvalid = 1'b1;
			next_rresp = `MFS_RESP_OKAY;
			case (rd_sel)
				mfs_pkg::MFS_SEL_STATUS: next_rdata = status_word; // [RULE4]
				mfs_pkg::MFS_SEL_MASK: next_rdata = {28'h0000000, mask};
				mfs_pkg::MFS_SEL_ADDR: next_rdata = MEM_FAULT_ADDRESS_REG;
				mfs_pkg::MFS_SEL_CTRL: next_rdata = {31'h00000000, prot_en};
				default: begin
					next_rdata = 32'h0000_0000;
					next_rresp = `MFS_RESP_SLVERR;
				end
			endcase
		end else if (RVALID && RREADY) begin
			next_rvalid = 1'b0;
		end
	end

	// Flag sets and the consequences handed back to the core
	always_comb begin
		flag_set = '0;
		flag_set[mfs_pkg::MFS_FL_UNSTACK] = unstack_evt; // [RULE1]
		flag_set[mfs_pkg::MFS_FL_DATA] = data_evt; // [RULE5]
		flag_set[mfs_pkg::MFS_FL_INSTR] = instr_evt; // [RULE7]
		// Only the data fault loads the address, so only it marks it valid
		flag_set[mfs_pkg::MFS_FL_VALID] = data_evt; // [RULE10]
		next_fault_addr = data_evt ? ACCESS_ADDR : MEM_FAULT_ADDRESS_REG; // [RULE6] [RULE9] [RULE2]
		// Unstack fault: chain to handler, SP untouched, no new save
		next_chain = unstack_evt; // [RULE2]
		// Stacked PC must name the faulting instruction
		next_stack_pc_valid = data_evt | instr_evt; // [RULE6] [RULE9]
		next_stack_pc = (data_evt | instr_evt) ? INSTR_PC : STACK_PC;
		next_irq = |(status_word[3:0] & mask);
	end

	// One sticky cell per flag
	genvar gi;
	generate
		for (gi = 0; gi < `MFS_NUM_FLAGS; gi++) begin : g_flag
			mfs_flag u_flag (
				.clk(CLK),
				.rst(RST),
				.set(flag_set[gi]),
				.clr(flag_clr[gi]),
				.q(flag_q[gi])
			);
		end
	endgenerate

	// Bus and control registers
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 4'h0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			AWREADY <= 1'b0;
			WREADY <= 1'b0;
			ARREADY <= 1'b0;
			BVALID <= 1'b0;
			BRESP <= `MFS_RESP_OKAY;
			RVALID <= 1'b0;
			RDATA <= 32'h0000_0000;
			RRESP <= `MFS_RESP_OKAY;
			mask <= `MFS_MASK_RST;
			prot_en <= `MFS_CTRL_RST;
		end else begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			// Ready drops while a half is held or a response waits
			AWREADY <= ~next_aw_held & ~next_bvalid & ~(AWVALID & AWREADY);
			WREADY <= ~next_w_held & ~next_bvalid & ~(WVALID & WREADY);
			ARREADY <= ~next_rvalid & ~(ARVALID & ARREADY);
			BVALID <= next_bvalid;
			BRESP <= next_bresp;
			RVALID <= next_rvalid;
			RDATA <= next_rdata;
			RRESP <= next_rresp;
			mask <= next_mask;
			prot_en <= next_prot_en;
		end
	end

	// Core-facing registers
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			MEM_FAULT_ADDRESS_REG <= `MFS_ADDR_RST;
			FAULT_CHAIN <= 1'b0;
			SP_HOLD <= 1'b0;
			SAVE_SKIP <= 1'b0;
			STACK_PC_VALID <= 1'b0;
			STACK_PC <= 32'h0000_0000;
			IRQ <= 1'b0;
		end else begin
			MEM_FAULT_ADDRESS_REG <= next_fault_addr;
			FAULT_CHAIN <= next_chain;
			SP_HOLD <= next_chain;
			SAVE_SKIP <= next_chain;
			STACK_PC_VALID <= next_stack_pc_valid;
			STACK_PC <= next_stack_pc;
			IRQ <= next_irq;
		end
	end

	// Unstack fault and its three consequences one cycle later
	sequence seq_unstack;
		unstack_evt;
	endsequence
	sequence seq_chain;
		FAULT_CHAIN && SP_HOLD && SAVE_SKIP && status_word[`MFS_BIT_UNSTACK];
	endsequence

	AST_UNSTACK_SET: assert property (@(posedge CLK) disable iff (RST) // [RULE1]
		seq_unstack |=> status_word[`MFS_BIT_UNSTACK]) else $error("unstack flag not set");
	AST_UNSTACK_CHAIN: assert property (@(posedge CLK) disable iff (RST) // [RULE2]
		seq_unstack |=> seq_chain ##1 !FAULT_CHAIN || $past(unstack_evt))
		else $error("unstack fault not chained");
	AST_UNSTACK_NOADDR: assert property (@(posedge CLK) disable iff (RST) // [RULE2]
		unstack_evt && !data_evt |=> $stable(MEM_FAULT_ADDRESS_REG))
		else $error("unstack fault wrote address");
	AST_W1C_CLEAR: assert property (@(posedge CLK) disable iff (RST) // [RULE3]
		wr_fire && w_strb[0] && wr_sel == mfs_pkg::MFS_SEL_STATUS
		&& w_data[`MFS_BIT_DATA] && !data_evt |=> !status_word[`MFS_BIT_DATA])
		else $error("write one did not clear");
	AST_RSVD_ZERO: assert property (@(posedge CLK) disable iff (RST) // [RULE4]
		ARVALID && ARREADY && rd_sel == mfs_pkg::MFS_SEL_STATUS |=> RVALID && !RDATA[2])
		else $error("reserved bit not zero");
	AST_DATA_ADDR: assert property (@(posedge CLK) disable iff (RST) // [RULE5]
		data_evt |=> status_word[`MFS_BIT_DATA] && status_word[`MFS_BIT_ADDR_VALID]
		&& MEM_FAULT_ADDRESS_REG == $past(ACCESS_ADDR)) else $error("data fault not captured");
	AST_FAULT_PC: assert property (@(posedge CLK) disable iff (RST) // [RULE6]
		data_evt || instr_evt |=> STACK_PC_VALID && STACK_PC == $past(INSTR_PC))
		else $error("stacked PC not faulting one");
	AST_XN_FETCH: assert property (@(posedge CLK) disable iff (RST) // [RULE8]
		FETCH_VALID && EXECUTE_NEVER_REGION |=> status_word[`MFS_BIT_INSTR])
		else $error("execute-never fetch missed");
	AST_INSTR_NOADDR: assert property (@(posedge CLK) disable iff (RST) // [RULE9]
		instr_evt && !data_evt |=> $stable(MEM_FAULT_ADDRESS_REG)
		&& !$rose(status_word[`MFS_BIT_ADDR_VALID])) else $error("instr fault wrote address");
	AST_VALID_SOURCE: assert property (@(posedge CLK) disable iff (RST) // [RULE10]
		$rose(status_word[`MFS_BIT_ADDR_VALID]) |-> $past(data_evt))
		else $error("valid set without address");
	AST_ZERO_WRITE_KEEPS: assert property (@(posedge CLK) disable iff (RST) // [RULE11]
		wr_fire && wr_sel == mfs_pkg::MFS_SEL_STATUS && !w_data[`MFS_BIT_UNSTACK]
		&& status_word[`MFS_BIT_UNSTACK] |=> status_word[`MFS_BIT_UNSTACK])
		else $error("zero write cleared flag");

endmodule

// file: tb/mem_fault_status_low_bits_test.sv
`timescale 1ns/100ps
`include "mfs_params.svh"

// Bench for the fault status block: register bus tasks plus core events
module mem_fault_status_low_bits_test;
	logic CLK = 1'b0; // 250 MHz clock
	logic RST = 1'b1; // Async reset, held at start
	logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
	logic [3:0] AWADDR = 4'h0, ARADDR = 4'h0, WSTRB = 4'h0;
	logic [31:0] WDATA = 32'h0, ACCESS_ADDR = 32'h0, INSTR_PC = 32'h0;
	logic UNSTACK_VALID = 1'b0, UNSTACK_DENY = 1'b0, ACCESS_VALID = 1'b0, ACCESS_DENY = 1'b0;
	logic FETCH_VALID = 1'b0, FETCH_DENY = 1'b0, EXECUTE_NEVER_REGION = 1'b0;
	logic AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ; // Design outputs
	logic FAULT_CHAIN, SP_HOLD, SAVE_SKIP, STACK_PC_VALID;
	logic [1:0] BRESP, RRESP;
	logic [31:0] RDATA, STACK_PC, MEM_FAULT_ADDRESS_REG;
	int n_fail = 0; // Mismatches seen
	int checked = 0; // Comparisons made

	// Half period of 2 ns
	always #2 CLK = ~CLK;

	mfs_top dut (.CLK(CLK), .RST(RST), .AWVALID(AWVALID), .AWREADY(AWREADY), .AWADDR(AWADDR),
		.WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA), .WSTRB(WSTRB), .BVALID(BVALID),
		.BREADY(BREADY), .BRESP(BRESP), .ARVALID(ARVALID), .ARREADY(ARREADY), .ARADDR(ARADDR),
		.RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP),
		.UNSTACK_VALID(UNSTACK_VALID), .UNSTACK_DENY(UNSTACK_DENY), .ACCESS_VALID(ACCESS_VALID),
		.ACCESS_DENY(ACCESS_DENY), .ACCESS_ADDR(ACCESS_ADDR), .FETCH_VALID(FETCH_VALID),
		.FETCH_DENY(FETCH_DENY), .EXECUTE_NEVER_REGION(EXECUTE_NEVER_REGION), .INSTR_PC(INSTR_PC),
		.FAULT_CHAIN(FAULT_CHAIN), .SP_HOLD(SP_HOLD), .SAVE_SKIP(SAVE_SKIP),
		.STACK_PC_VALID(STACK_PC_VALID), .STACK_PC(STACK_PC),
		.MEM_FAULT_ADDRESS_REG(MEM_FAULT_ADDRESS_REG), .IRQ(IRQ));

	// Compare one value and report a mismatch at once
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Verdict; reached from the main sequence or the watchdog
	task automatic final_report;
		$display("Comparisons %0d, mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Write: address and data offered together, each dropped once taken
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] rsp);
		@(posedge CLK);
		AWADDR <= a;
		WDATA <= d;
		WSTRB <= 4'hF;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		// No local limit: only the watchdog ends a wait for a lost answer
		do begin
			@(posedge CLK);
			if (AWVALID && AWREADY) AWVALID <= 1'b0;
			if (WVALID && WREADY) WVALID <= 1'b0;
		end while (!BVALID);
		BREADY <= 1'b0;
		cmp({30'h0, BRESP}, {30'h0, rsp});
	endtask

	// Read: response and data taken at the edge where RVALID is seen
	task automatic rd(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] rsp);
		@(posedge CLK);
		ARADDR <= a;
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		do begin
			@(posedge CLK);
			if (ARVALID && ARREADY) ARVALID <= 1'b0;
		end while (!RVALID);
		RREADY <= 1'b0;
		cmp(RDATA, exp);
		cmp({30'h0, RRESP}, {30'h0, rsp});
	endtask

	// One-cycle core event, then check pulses, stacked PC and fault address
	// s = {unstack v/d, access v/d, fetch v/d, execute-never}; ep = {chain, sp, skip, pc valid}
	task automatic ev(input logic [6:0] s, input logic [31:0] a, input logic [31:0] pc,
		input logic [3:0] ep, input logic [31:0] ea);
		@(posedge CLK);
		{UNSTACK_VALID, UNSTACK_DENY, ACCESS_VALID, ACCESS_DENY, FETCH_VALID, FETCH_DENY,
			EXECUTE_NEVER_REGION} <= s;
		ACCESS_ADDR <= a;
		INSTR_PC <= pc;
		@(posedge CLK);
		{UNSTACK_VALID, UNSTACK_DENY, ACCESS_VALID, ACCESS_DENY, FETCH_VALID, FETCH_DENY,
			EXECUTE_NEVER_REGION} <= 7'h00;
		// Inverted so a stale capture cannot pass unnoticed
		ACCESS_ADDR <= ~a;
		INSTR_PC <= ~pc;
		#1;
		cmp({28'h0, FAULT_CHAIN, SP_HOLD, SAVE_SKIP, STACK_PC_VALID}, {28'h0, ep});
		cmp(MEM_FAULT_ADDRESS_REG, ea);
		if (ep[0]) cmp(STACK_PC, pc);
	endtask

	// Main sequence
	initial begin
		repeat (3) @(posedge CLK);
		RST <= 1'b0;
		@(posedge CLK);
		rd(`MFS_OFF_STATUS, 32'h0, `MFS_RESP_OKAY);
		rd(`MFS_OFF_MASK, 32'h0, `MFS_RESP_OKAY);
		rd(`MFS_OFF_ADDR, 32'h0, `MFS_RESP_OKAY);
		rd(`MFS_OFF_CTRL, 32'h0, `MFS_RESP_OKAY);
		wr(`MFS_OFF_CTRL, 32'h1, `MFS_RESP_OKAY);
		ev(7'b0011000, 32'h2000_1234, 32'h0000_0ABC, 4'h1, 32'h2000_1234);
		rd(`MFS_OFF_STATUS, 32'h82, `MFS_RESP_OKAY);
		ev(7'b0000110, 32'h3000_0000, 32'h0000_0DE0, 4'h1, 32'h2000_1234);
		rd(`MFS_OFF_STATUS, 32'h83, `MFS_RESP_OKAY);
		wr(`MFS_OFF_STATUS, 32'h0, `MFS_RESP_OKAY);
		rd(`MFS_OFF_STATUS, 32'h83, `MFS_RESP_OKAY);
		wr(`MFS_OFF_STATUS, 32'h4, `MFS_RESP_OKAY);
		rd(`MFS_OFF_STATUS, 32'h83, `MFS_RESP_OKAY);
		wr(`MFS_OFF_STATUS, 32'hFF, `MFS_RESP_OKAY);
		rd(`MFS_OFF_STATUS, 32'h0, `MFS_RESP_OKAY);
		// Unstack fault must chain and leave the captured address alone
		ev(7'b1100000, 32'h4000_0000, 32'h0000_0F00, 4'hE, 32'h2000_1234);
		rd(`MFS_OFF_STATUS, 32'h08, `MFS_RESP_OKAY);
		// Zero write while the unstack flag is up must leave it set
		wr(`MFS_OFF_STATUS, 32'h0, `MFS_RESP_OKAY);
		rd(`MFS_OFF_STATUS, 32'h08, `MFS_RESP_OKAY);
		wr(`MFS_OFF_STATUS, 32'h08, `MFS_RESP_OKAY);
		wr(`MFS_OFF_CTRL, 32'h0, `MFS_RESP_OKAY);
		// Protection off: denials ignored, execute-never still faults
		ev(7'b0011000, 32'h5000_0000, 32'h0000_0100, 4'h0, 32'h2000_1234);
		ev(7'b0000110, 32'h5000_0000, 32'h0000_0104, 4'h0, 32'h2000_1234);
		ev(7'b0000101, 32'h5000_0000, 32'h0000_0108, 4'h1, 32'h2000_1234);
		rd(`MFS_OFF_STATUS, 32'h01, `MFS_RESP_OKAY);
		// Interrupt: masked off, unmasked on, cleared off
		cmp({31'h0, IRQ}, 32'h0);
		wr(`MFS_OFF_MASK, 32'hF, `MFS_RESP_OKAY);
		rd(`MFS_OFF_MASK, 32'h0B, `MFS_RESP_OKAY);
		cmp({31'h0, IRQ}, 32'h1);
		wr(`MFS_OFF_STATUS, 32'h01, `MFS_RESP_OKAY);
		repeat (2) @(posedge CLK);
		#1;
		cmp({31'h0, IRQ}, 32'h0);
		// Unmapped offset is refused
		wr(4'h2, 32'hF, `MFS_RESP_SLVERR);
		rd(4'h2, 32'h0, `MFS_RESP_SLVERR);
		// Clear lands on the same edge as a new fault: the fault must survive
		fork
			wr(`MFS_OFF_STATUS, 32'h01, `MFS_RESP_OKAY);
			begin
				@(posedge CLK);
				ev(7'b0000101, 32'h6000_0000, 32'h0000_0200, 4'h1, 32'h2000_1234);
			end
		join
		rd(`MFS_OFF_STATUS, 32'h01, `MFS_RESP_OKAY);
		// Mid-run reset must bring every sticky flag back to zero
		@(posedge CLK);
		RST <= 1'b1;
		repeat (3) @(posedge CLK);
		RST <= 1'b0;
		@(posedge CLK);
		rd(`MFS_OFF_STATUS, 32'h0, `MFS_RESP_OKAY);
		final_report();
	end

	// Watchdog: the sequence needs well under a thousand cycles
	initial begin
		repeat (3000) @(posedge CLK);
		n_fail++;
		final_report();
	end
endmodule
